// [rtl/hps_pin_setup.sv]
// hardware pin setup register with AHB-Lite slave and pin behaviour
//
// Notes on behaviour
// (RQ1) reset value follows the per-field reset annotation
// (RQ2) pin setup register sits at A4h
// (RQ3) bit 27 set disables bus voltage filter
// (RQ4) bits 10-9 pick feedback level when stopped
// (RQ5) bits 8-7 pick feedback level on fault
// (RQ6) bit 6 enables the alarm pin
// (RQ7) bit 5 picks low-side or align braking
// (RQ8) bit 4 picks align brake angle source
// (RQ9) bits 3-2 override the brake pin
// (RQ10) bits 1-0 select speed pin input mode
// (RQ11) software writes reserved bits back unchanged
`timescale 1ns/1ps
`default_nettype none
module hps_pin_setup #(
  parameter int ANGLE_WIDTH = 16,
  parameter logic [31:0] PIN_SETUP_RESET = hps_pkg::HPS_PIN_SETUP_RESET
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic brake_pin,
  input wire logic feedback_drive,
  input wire logic motor_stopped,
  input wire logic fault_active,
  input wire logic speed_feedback_coast_option,
  input wire logic backemf_above_threshold,
  input wire logic alarm_request,
  input wire logic [ANGLE_WIDTH-1:0] commutation_angle,
  input wire logic [ANGLE_WIDTH-1:0] align_angle,
  output logic speed_feedback_output,
  output logic alarm_out,
  output logic bus_voltage_filter_on,
  output logic low_side_brake,
  output logic align_brake,
  output logic [ANGLE_WIDTH-1:0] brake_angle,
  output logic [1:0] speed_mode,
  output logic speed_mode_analog,
  output logic speed_mode_pwm,
  output logic speed_mode_frequency
);
  localparam int HPS_SYNC_STAGES_L = hps_pkg::HPS_SYNC_STAGES;

  // brake action states, one-hot so each brake pin is a one-bit decode
  typedef enum logic [2:0] {
    HPS_BRAKE_OFF = 3'b001,
    HPS_BRAKE_LOW = 3'b010,
    HPS_BRAKE_ALIGN = 3'b100
  } hps_brake_state_type;

  // stored register and live status
  logic [31:0] pin_setup;
  logic [hps_pkg::HPS_ST_WIDTH-1:0] status;

  // bus address and data phase tracking
  logic phase_write;
  logic phase_pin_setup;
  logic write_pin_setup;
  logic addr_valid;
  logic addr_pin_setup;
  logic addr_status;
  logic [31:0] next_rdata;
  logic [31:0] pin_setup_view;

  // brake pin path and brake action
  logic [HPS_SYNC_STAGES_L-1:0] brake_sync;
  logic brake_level;
  logic brake_request;
  logic brake_active;
  logic [1:0] brake_override;
  logic brake_mode_align;
  hps_brake_state_type brake_state;
  hps_brake_state_type next_brake_state;
  logic [ANGLE_WIDTH-1:0] held_angle;

  // zero wait states, every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase decode; only word writes take effect, reads of any size are answered
  assign addr_valid = hsel && hready && (htrans == hps_pkg::HPS_HTRANS_NONSEQ);
  assign addr_pin_setup = (haddr[hps_pkg::HPS_ADDR_WIDTH-1:0]
                           == hps_pkg::HPS_PIN_SETUP_OFFSET)
                          && (haddr[31:hps_pkg::HPS_ADDR_WIDTH] == 20'h0_0000); // RQ2
  assign addr_status = (haddr[hps_pkg::HPS_ADDR_WIDTH-1:0] == hps_pkg::HPS_STATUS_OFFSET)
                       && (haddr[31:hps_pkg::HPS_ADDR_WIDTH] == 20'h0_0000);

  // carry a write into its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_write <= 1'b0;
      phase_pin_setup <= 1'b0;
    end else begin
      phase_write <= addr_valid && hwrite && (hsize == hps_pkg::HPS_HSIZE_WORD);
      phase_pin_setup <= addr_valid && addr_pin_setup;
    end
  end

  // data phase of an accepted word write to the setup register
  assign write_pin_setup = phase_write && phase_pin_setup;

  // the register itself; reserved bits just store what software gives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_setup <= PIN_SETUP_RESET; // RQ1
    end else if (write_pin_setup) begin
      pin_setup <= hwdata; // RQ11
    end
  end

  // forward a write in flight so a back-to-back read sees fresh data
  assign pin_setup_view = write_pin_setup ? hwdata : pin_setup;

  // read data captured at the address phase, unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_pin_setup) begin
      next_rdata = pin_setup_view;
    end else if (addr_status) begin
      next_rdata = {27'h000_0000, status};
    end
  end

  // only read address phases reload, so data stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // brake pin synchroniser; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brake_sync[0] <= 1'b0;
    end else begin
      brake_sync[0] <= brake_pin;
    end
  end

  // later stages each copy the stage before them
  for (genvar stage = 1; stage < HPS_SYNC_STAGES_L; stage++) begin : g_brake_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        brake_sync[stage] <= 1'b0;
      end else begin
        brake_sync[stage] <= brake_sync[stage-1];
      end
    end
  end

  // a level change counts only once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brake_level <= 1'b0;
    end else if (brake_sync[1] == brake_sync[2]) begin
      brake_level <= brake_sync[2];
    end
  end

  // brake fields read straight from the stored register
  assign brake_override = pin_setup[hps_pkg::HPS_BRAKE_OVR_MSB:hps_pkg::HPS_BRAKE_OVR_LSB];
  assign brake_mode_align = pin_setup[hps_pkg::HPS_BRAKE_MODE_BIT];

  // override: codes 0 and 3 follow the pin
  always_comb begin
    case (brake_override)
      hps_pkg::HPS_CODE_1: brake_request = 1'b1; // RQ9
      hps_pkg::HPS_CODE_2: brake_request = 1'b0; // RQ9
      default: brake_request = brake_level; // RQ9
    endcase
  end

  // mode is read every cycle, so a mode write moves an active brake at once
  always_comb begin
    next_brake_state = HPS_BRAKE_OFF;
    case (brake_state)
      HPS_BRAKE_OFF, HPS_BRAKE_LOW, HPS_BRAKE_ALIGN: begin
        if (brake_request && brake_mode_align) begin
          next_brake_state = HPS_BRAKE_ALIGN; // RQ7
        end else if (brake_request) begin
          next_brake_state = HPS_BRAKE_LOW; // RQ7
        end
      end
      default: begin
        next_brake_state = HPS_BRAKE_OFF;
      end
    endcase
  end

  // brake state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brake_state <= HPS_BRAKE_OFF;
    end else begin
      brake_state <= next_brake_state;
    end
  end

  // one-hot decode, so only one brake kind can ever be shown
  assign low_side_brake = (brake_state == HPS_BRAKE_LOW); // RQ7
  assign align_brake = (brake_state == HPS_BRAKE_ALIGN); // RQ7
  assign brake_active = (brake_state != HPS_BRAKE_OFF);

  // freeze the commutation angle on the cycle braking starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_angle <= '0;
    end else if (brake_request && !brake_active) begin
      held_angle <= commutation_angle; // RQ8
    end else if (!brake_request) begin
      held_angle <= commutation_angle;
    end
  end

  // angle source for align braking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brake_angle <= '0;
    end else if (pin_setup[hps_pkg::HPS_ANGLE_SEL_BIT]) begin
      brake_angle <= align_angle; // RQ8
    end else if (brake_request && !brake_active) begin
      brake_angle <= commutation_angle; // RQ8
    end else begin
      brake_angle <= held_angle; // RQ8
    end
  end

  // alarm pin gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= alarm_request && pin_setup[hps_pkg::HPS_ALARM_EN_BIT]; // RQ6
    end
  end

  // bus voltage filter; runs unless software turns it off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_voltage_filter_on <= 1'b1;
    end else begin
      bus_voltage_filter_on <= !pin_setup[hps_pkg::HPS_FILTER_OFF_BIT]; // RQ3
    end
  end

  // raw speed pin code for the speed input logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_mode <= 2'h0;
    end else begin
      speed_mode <= pin_setup[hps_pkg::HPS_SPEED_MODE_MSB:hps_pkg::HPS_SPEED_MODE_LSB];
    end
  end

  // speed pin interpretation; code 2 selects none of the modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_mode_analog <= 1'b1;
      speed_mode_pwm <= 1'b0;
      speed_mode_frequency <= 1'b0;
    end else begin
      speed_mode_analog <= (pin_setup[1:0] == hps_pkg::HPS_CODE_0); // RQ10
      speed_mode_pwm <= (pin_setup[1:0] == hps_pkg::HPS_CODE_1); // RQ10
      speed_mode_frequency <= (pin_setup[1:0] == hps_pkg::HPS_CODE_3); // RQ10
    end
  end

  // feedback output level selection
  hps_feedback u_feedback (
    .hclk(hclk),
    .hresetn(hresetn),
    .feedback_drive(feedback_drive),
    .motor_stopped(motor_stopped),
    .fault_active(fault_active),
    .speed_feedback_coast_option(speed_feedback_coast_option),
    .backemf_above_threshold(backemf_above_threshold),
    .speed_feedback_stop_level(
      pin_setup[hps_pkg::HPS_STOP_LEVEL_MSB:hps_pkg::HPS_STOP_LEVEL_LSB]), // RQ4
    .speed_feedback_fault_level(
      pin_setup[hps_pkg::HPS_FAULT_LEVEL_MSB:hps_pkg::HPS_FAULT_LEVEL_LSB]), // RQ5
    .speed_feedback_output(speed_feedback_output)
  );

  // live state for software
  always_comb begin
    status = '0;
    status[hps_pkg::HPS_ST_BRAKE_PIN] = brake_level;
    status[hps_pkg::HPS_ST_BRAKE_ACTIVE] = low_side_brake;
    status[hps_pkg::HPS_ST_ALIGN_ACTIVE] = align_brake;
    status[hps_pkg::HPS_ST_FEEDBACK] = speed_feedback_output;
    status[hps_pkg::HPS_ST_ALARM] = alarm_out;
  end
endmodule : hps_pin_setup
`default_nettype wire

// [rtl/hps_pkg.sv]
// constants for the hardware pin setup register bank
package hps_pkg;
  // byte addresses on the register bus
  localparam logic [11:0] HPS_PIN_SETUP_OFFSET = 12'h0A4;
  localparam logic [11:0] HPS_STATUS_OFFSET = 12'h0F0;
  localparam int HPS_ADDR_WIDTH = 12;
  // documented field positions of the pin setup register
  localparam int HPS_FILTER_OFF_BIT = 27;
  localparam int HPS_STOP_LEVEL_MSB = 10;
  localparam int HPS_STOP_LEVEL_LSB = 9;
  localparam int HPS_FAULT_LEVEL_MSB = 8;
  localparam int HPS_FAULT_LEVEL_LSB = 7;
  localparam int HPS_ALARM_EN_BIT = 6;
  localparam int HPS_BRAKE_MODE_BIT = 5;
  localparam int HPS_ANGLE_SEL_BIT = 4;
  localparam int HPS_BRAKE_OVR_MSB = 3;
  localparam int HPS_BRAKE_OVR_LSB = 2;
  localparam int HPS_SPEED_MODE_MSB = 1;
  localparam int HPS_SPEED_MODE_LSB = 0;
  // reset value: documented fields are zero, the reserved 26..11 span is part specific
  localparam logic [31:0] HPS_PIN_SETUP_RESET = 32'h0000_0000;
  // two-bit field codes
  localparam logic [1:0] HPS_CODE_0 = 2'h0;
  localparam logic [1:0] HPS_CODE_1 = 2'h1;
  localparam logic [1:0] HPS_CODE_2 = 2'h2;
  localparam logic [1:0] HPS_CODE_3 = 2'h3;
  // status register bit positions
  localparam int HPS_ST_BRAKE_PIN = 0;
  localparam int HPS_ST_BRAKE_ACTIVE = 1;
  localparam int HPS_ST_ALIGN_ACTIVE = 2;
  localparam int HPS_ST_FEEDBACK = 3;
  localparam int HPS_ST_ALARM = 4;
  localparam int HPS_ST_WIDTH = 5;
  // AHB encodings and brake synchroniser depth
  localparam logic [1:0] HPS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HPS_HSIZE_WORD = 3'h2;
  localparam int HPS_SYNC_STAGES = 3;
endpackage : hps_pkg

// [rtl/hps_feedback.sv]
// speed feedback output selection for stop and fault conditions
`timescale 1ns/1ps
`default_nettype none
module hps_feedback (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic feedback_drive,
  input wire logic motor_stopped,
  input wire logic fault_active,
  input wire logic speed_feedback_coast_option,
  input wire logic backemf_above_threshold,
  input wire logic [1:0] speed_feedback_stop_level,
  input wire logic [1:0] speed_feedback_fault_level,
  output logic speed_feedback_output
);
  logic last_driven;
  logic next_feedback;

  // remember the level last shown while the motor was really driven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_driven <= 1'b0;
    end else if (!motor_stopped && !fault_active) begin
      last_driven <= feedback_drive;
    end
  end

  // fault wins over stop, since a fault may also stop the motor
  always_comb begin
    next_feedback = feedback_drive;
    if (fault_active) begin
      case (speed_feedback_fault_level)
        hps_pkg::HPS_CODE_0: next_feedback = last_driven; // RQ5
        hps_pkg::HPS_CODE_1: next_feedback = 1'b1; // RQ5
        hps_pkg::HPS_CODE_2: next_feedback = 1'b0; // RQ5
        default: begin
          // keep toggling only while back-emf is still above threshold
          if (speed_feedback_coast_option && backemf_above_threshold) begin
            next_feedback = feedback_drive; // RQ5
          end else begin
            next_feedback = last_driven; // RQ5
          end
        end
      endcase
    end else if (motor_stopped) begin
      case (speed_feedback_stop_level)
        hps_pkg::HPS_CODE_0: begin
          // end state left to the coasting option
          if (speed_feedback_coast_option) begin
            next_feedback = feedback_drive; // RQ4
          end else begin
            next_feedback = last_driven; // RQ4
          end
        end
        hps_pkg::HPS_CODE_2: next_feedback = 1'b0; // RQ4
        default: next_feedback = 1'b1; // RQ4
      endcase
    end
  end

  // registered so the pin never glitches between modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_feedback_output <= 1'b0;
    end else begin
      speed_feedback_output <= next_feedback;
    end
  end
endmodule : hps_feedback
`default_nettype wire

// [verif/hps_pin_setup_chk.sv]
// checker for the hardware pin setup register bank
`timescale 1ns/1ps
`default_nettype none
module hps_pin_setup_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic feedback_drive,
  input wire logic motor_stopped,
  input wire logic fault_active,
  input wire logic alarm_request,
  input wire logic speed_feedback_output,
  input wire logic alarm_out,
  input wire logic low_side_brake,
  input wire logic align_brake,
  input wire logic [1:0] speed_mode,
  input wire logic speed_mode_analog,
  input wire logic speed_mode_pwm,
  input wire logic speed_mode_frequency
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read address phase accepted by the slave
  logic rd_take;
  assign rd_take = hsel && hready && htrans == 2'h2 && !hwrite;
  // bus answers with no wait and no error
  a_ready_always: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  // unmapped reads return zero, data stands between reads
  a_unmapped_zero: assert property (rd_take && haddr == 32'h0000_0100 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  // decodes must agree with the stored speed mode
  a_mode_decode: assert property ({speed_mode_analog, speed_mode_pwm, speed_mode_frequency} ==
    {speed_mode == 2'h0, speed_mode == 2'h1, speed_mode == 2'h3}) else $error("mode decode wrong");
  a_brake_exclusive: assert property (!(low_side_brake && align_brake))
    else $error("both brake kinds active");
  a_alarm_cause: assert property (alarm_out |-> $past(alarm_request))
    else $error("alarm without request");
  // running motor: feedback follows the driven level one cycle later
  a_feedback_run: assert property (!$past(fault_active) && !$past(motor_stopped) |->
    speed_feedback_output == $past(feedback_drive)) else $error("feedback not following drive");
endmodule : hps_pin_setup_chk
bind hps_pin_setup hps_pin_setup_chk u_hps_pin_setup_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .feedback_drive, .motor_stopped,
  .fault_active, .alarm_request, .speed_feedback_output, .alarm_out, .low_side_brake,
  .align_brake, .speed_mode, .speed_mode_analog, .speed_mode_pwm, .speed_mode_frequency);
`default_nettype wire

// [verif/tb_hps_pin_setup.sv]
// self-checking bench for the hardware pin setup register bank
`timescale 1ns/1ps
`default_nettype none
module tb_hps_pin_setup;
  logic hclk, hresetn, hsel, hwrite, brake_pin, feedback_drive, motor_stopped, fault_active;
  logic coast, bemf, alarm_request, hreadyout, hresp, speed_feedback_output, alarm_out;
  logic bus_voltage_filter_on, low_side_brake, align_brake, sm_a, sm_p, sm_f;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, speed_mode;
  logic [2:0] hsize;
  logic [15:0] commutation_angle, align_angle, brake_angle;
  int n_errors = 0;
  int n_checks = 0;
  hps_pin_setup u_hps_pin_setup (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .brake_pin, .feedback_drive,
    .motor_stopped, .fault_active, .speed_feedback_coast_option(coast),
    .backemf_above_threshold(bemf), .alarm_request, .commutation_angle, .align_angle,
    .speed_feedback_output, .alarm_out, .bus_voltage_filter_on, .low_side_brake, .align_brake,
    .brake_angle, .speed_mode, .speed_mode_analog(sm_a), .speed_mode_pwm(sm_p),
    .speed_mode_frequency(sm_f));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one single AHB transfer; hready is the slave's own hreadyout
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus
  // write the setup register, then let the brake synchroniser settle
  task automatic put(input logic [31:0] d);
    bus(1'b1, 32'h0000_00A4, d);
    repeat (6) @(posedge hclk);
  endtask : put
  task automatic t_reset;
    bus(1'b0, 32'h0000_00A4, 32'h0);
    chk("reset value", 32'h0, rd);
    chk("filter after reset", 32'h1, 32'(bus_voltage_filter_on));
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    bus(1'b1, 32'h0000_00A4, 32'hA5A5_5A5A);
    bus(1'b0, 32'h0000_00A4, 32'h0);
    chk("readback", 32'hA5A5_5A5A, rd);
    bus(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0100, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b0, 32'h0000_00A4, 32'h0);
    chk("reserved kept", 32'hA5A5_5A5A, rd);
    $display("test registers done");
  endtask : t_regs
  task automatic t_filter;
    put(32'h0800_0000);
    chk("filter disabled", 32'h0, 32'(bus_voltage_filter_on));
    put(32'h0);
    chk("filter enabled", 32'h1, 32'(bus_voltage_filter_on));
    $display("test filter done");
  endtask : t_filter
  task automatic t_speed;
    for (int i = 0; i < 4; i++) begin
      put(32'(i));
      chk("speed mode", 32'(i), 32'(speed_mode));
      chk("mode decode", {29'h0, i == 0, i == 1, i == 3}, {29'h0, sm_a, sm_p, sm_f});
    end
    $display("test speed mode done");
  endtask : t_speed
  task automatic t_alarm;
    alarm_request <= 1'b1;
    put(32'h0);
    chk("alarm disabled", 32'h0, 32'(alarm_out));
    put(32'h0000_0040);
    chk("alarm enabled", 32'h1, 32'(alarm_out));
    alarm_request <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("alarm released", 32'h0, 32'(alarm_out));
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_feedback;
    feedback_drive <= 1'b0;
    motor_stopped <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      put(32'(c) << 9);
      chk("stop level", 32'(c != 2), 32'(speed_feedback_output));
    end
    fault_active <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      put(32'(c) << 7);
      chk("fault level", 32'(c == 1), 32'(speed_feedback_output));
    end
    // fault code 3 tracks drive only while back-emf stays high
    coast <= 1'b1;
    bemf <= 1'b1;
    feedback_drive <= 1'b1;
    put(32'h0000_0180);
    chk("fault active level", 32'h1, 32'(speed_feedback_output));
    // drive stays high, so a held level differs from a followed one
    bemf <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("fault below bemf", 32'h0, 32'(speed_feedback_output));
    // stop code 0 follows drive only with the coasting option on
    fault_active <= 1'b0;
    put(32'h0);
    chk("stop coast follows", 32'h1, 32'(speed_feedback_output));
    coast <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("stop coast held", 32'h0, 32'(speed_feedback_output));
    {fault_active, motor_stopped, coast} <= 3'h0;
    $display("test feedback done");
  endtask : t_feedback
  task automatic t_brake;
    brake_pin <= 1'b1;
    put(32'h0);
    chk("low side brake", 32'h2, {low_side_brake, align_brake});
    brake_pin <= 1'b0;
    put(32'h0000_0030);
    brake_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("align configured", 32'h1_0ABC, {low_side_brake, align_brake, brake_angle});
    brake_pin <= 1'b0;
    put(32'h0000_0020);
    brake_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    commutation_angle <= 16'h5555;
    repeat (3) @(posedge hclk);
    chk("align last angle", 32'h1_1234, {low_side_brake, align_brake, brake_angle});
    put(32'h0000_0008);
    chk("override off", 32'h0, {low_side_brake, align_brake});
    brake_pin <= 1'b0;
    put(32'h0000_0004);
    chk("override on", 32'h2, {low_side_brake, align_brake});
    // status word: low-side brake on, feedback high from the running motor
    bus(1'b0, 32'h0000_00F0, 32'h0);
    chk("status word", 32'h0000_000A, rd);
    put(32'h0000_000C);
    chk("pin follows", 32'h0, {low_side_brake, align_brake});
    $display("test brake done");
  endtask : t_brake
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, brake_pin, feedback_drive, motor_stopped, fault_active} = 6'h0;
    {coast, bemf, alarm_request, htrans, hsize} = 8'h0;
    {haddr, hwdata} = 64'h0;
    commutation_angle = 16'h1234;
    align_angle = 16'h0ABC;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_filter;
    t_speed;
    t_alarm;
    t_feedback;
    t_brake;
    final_report;
  end
  // the run needs well under 2000 cycles; cut a hang short
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
endmodule : tb_hps_pin_setup
`default_nettype wire
